/* File: inc/pecint_pkg.sv */
`default_nettype none
package pecint_pkg;
  localparam int PECINT_PINS = 8;
  localparam int PECINT_ADDR_W = 12;
  localparam int PECINT_DATA_W = 32;
  localparam int PECINT_STRB_W = 4;
  typedef logic [PECINT_PINS-1:0] pecint_pins_t;
  typedef logic [PECINT_ADDR_W-1:0] pecint_addr_t;
  typedef logic [PECINT_DATA_W-1:0] pecint_data_t;
  typedef logic [PECINT_STRB_W-1:0] pecint_strb_t;

  // Register byte offsets
  localparam pecint_addr_t PECINT_RISE_OFF = 12'h000;
  localparam pecint_addr_t PECINT_FALL_OFF = 12'h004;
  localparam pecint_addr_t PECINT_FLAG_OFF = 12'h008;
  localparam pecint_addr_t PECINT_CTRL_OFF = 12'h00c;

  // Reset values
  localparam pecint_pins_t PECINT_EN_RESET = 8'h00;
  localparam pecint_pins_t PECINT_FLAG_RESET = 8'h00;
  localparam logic PECINT_MASTER_RESET = 1'h0;
  localparam pecint_data_t PECINT_DATA_ZERO = 32'h0000_0000;

  // Fields of core_interrupt_control
  localparam int PECINT_CTRL_MASTER_BIT = 0;
  localparam int PECINT_CTRL_SUMMARY_BIT = 1;
  localparam int PECINT_LOW_LANE = 0;

  // Pin sampling: two sync stages plus one history stage must fill
  localparam logic [1:0] PECINT_SETTLE_CYCLES = 2'h3;
  localparam logic [1:0] PECINT_SETTLE_ZERO = 2'h0;
  localparam logic [1:0] PECINT_SETTLE_STEP = 2'h1;

  typedef enum {
    PECINT_REG_RISE,
    PECINT_REG_FALL,
    PECINT_REG_FLAG,
    PECINT_REG_CTRL,
    PECINT_REG_NONE
  } pecint_reg_t;

  function automatic pecint_reg_t pecint_decode(input pecint_addr_t addr);
    unique case (addr)
      PECINT_RISE_OFF: pecint_decode = PECINT_REG_RISE;
      PECINT_FALL_OFF: pecint_decode = PECINT_REG_FALL;
      PECINT_FLAG_OFF: pecint_decode = PECINT_REG_FLAG;
      PECINT_CTRL_OFF: pecint_decode = PECINT_REG_CTRL;
      default: pecint_decode = PECINT_REG_NONE;
    endcase
  endfunction
endpackage
`default_nettype wire

/* File: inc/pecint_det_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pecint_det_if;
  import pecint_pkg::*;
  pecint_pins_t rise_en;
  pecint_pins_t fall_en;
  pecint_pins_t detect;
  modport det (input rise_en, input fall_en, output detect);
  modport ctl (output rise_en, output fall_en, input detect);
endinterface
`default_nettype wire

/* File: rtl/pecint_edge.sv */
`timescale 1ns/1ps
`default_nettype none
module pecint_edge (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Port pins
  input wire pecint_pkg::pecint_pins_t port_pin_n,
  // Enables in, detections out
  pecint_det_if.det det
);
  import pecint_pkg::*;

  pecint_pins_t sync_a, sync_b, prev;
  pecint_pins_t next_sync_a, next_sync_b, next_prev;
  logic [1:0] settle, next_settle;
  pecint_pins_t rise, fall;

  always_comb begin
    next_sync_a = port_pin_n;
    next_sync_b = sync_a;
    next_prev = sync_b;
    next_settle = (settle == PECINT_SETTLE_CYCLES) ? settle : settle + PECINT_SETTLE_STEP;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= PECINT_FLAG_RESET;
      sync_b <= PECINT_FLAG_RESET;
      prev <= PECINT_FLAG_RESET;
      settle <= PECINT_SETTLE_ZERO;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      prev <= next_prev;
      settle <= next_settle;
    end
  end

  // Until history holds real samples, a pin high at reset would look like a rise
  always_comb begin
    rise = (settle == PECINT_SETTLE_CYCLES) ? (sync_b & ~prev) : PECINT_FLAG_RESET;
    fall = (settle == PECINT_SETTLE_CYCLES) ? (~sync_b & prev) : PECINT_FLAG_RESET;
    det.detect = (rise & det.rise_en) | (fall & det.fall_en);
  end
endmodule
`default_nettype wire

/* File: rtl/pecint_top.sv */
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pecint_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire pecint_pkg::pecint_addr_t paddr,
  input wire pecint_pkg::pecint_data_t pwdata,
  input wire pecint_pkg::pecint_strb_t pstrb,
  output pecint_pkg::pecint_data_t prdata,
  output logic pready,
  output logic pslverr,
  // Port pins and core
  input wire pecint_pkg::pecint_pins_t port_pin_n,
  input wire logic sleep_state,
  output logic change_irq,
  output logic wake_request
);
  import pecint_pkg::*;

  pecint_det_if det_bus ();

  pecint_edge pecint_edge_i (
    .pclk(pclk),
    .presetn(presetn),
    .port_pin_n(port_pin_n),
    .det(det_bus.det)
  );

  pecint_pins_t rising_edge_enable, next_rising_edge_enable;
  pecint_pins_t falling_edge_enable, next_falling_edge_enable;
  pecint_pins_t pin_change_flags, next_pin_change_flags;
  logic change_irq_master_enable, next_change_irq_master_enable;
  logic change_irq_summary_flag;
  pecint_data_t next_prdata;
  logic next_pready, next_pslverr, next_change_irq, next_wake_request;
  logic setup_phase, write_commit;
  pecint_reg_t setup_reg, access_reg;

  assign det_bus.rise_en = rising_edge_enable;
  assign det_bus.fall_en = falling_edge_enable;

  // Summary is a pure function of the flags, so it can never disagree with them
  assign change_irq_summary_flag = |pin_change_flags;

  assign setup_phase = psel && !penable;
  assign setup_reg = pecint_decode(paddr);
  assign access_reg = pecint_decode(paddr);
  // Zero wait state: pready is high in every access phase, so this is the commit edge
  assign write_commit = psel && penable && pready && pwrite && pstrb[PECINT_LOW_LANE];

  // Register file
  always_comb begin
    next_rising_edge_enable = rising_edge_enable;
    next_falling_edge_enable = falling_edge_enable;
    next_change_irq_master_enable = change_irq_master_enable;
    next_pin_change_flags = pin_change_flags;
    if (write_commit) begin
      unique case (access_reg)
        PECINT_REG_RISE: next_rising_edge_enable = pwdata[PECINT_PINS-1:0];
        PECINT_REG_FALL: next_falling_edge_enable = pwdata[PECINT_PINS-1:0];
        PECINT_REG_FLAG: next_pin_change_flags = pwdata[PECINT_PINS-1:0];
        PECINT_REG_CTRL:
          next_change_irq_master_enable = pwdata[PECINT_CTRL_MASTER_BIT];
        PECINT_REG_NONE: next_pin_change_flags = pin_change_flags;
      endcase
    end
    // Set wins over any written value; detection ignores the master enable
    next_pin_change_flags = next_pin_change_flags | det_bus.detect;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rising_edge_enable <= PECINT_EN_RESET;
      falling_edge_enable <= PECINT_EN_RESET;
      pin_change_flags <= PECINT_FLAG_RESET;
      change_irq_master_enable <= PECINT_MASTER_RESET;
    end else begin
      rising_edge_enable <= next_rising_edge_enable;
      falling_edge_enable <= next_falling_edge_enable;
      pin_change_flags <= next_pin_change_flags;
      change_irq_master_enable <= next_change_irq_master_enable;
    end
  end

  // Bus answer, prepared in the setup phase
  always_comb begin
    next_pready = setup_phase;
    next_pslverr = setup_phase && (setup_reg == PECINT_REG_NONE);
    next_prdata = PECINT_DATA_ZERO;
    if (setup_phase && !pwrite) begin
      unique case (setup_reg)
        PECINT_REG_RISE: next_prdata[PECINT_PINS-1:0] = rising_edge_enable;
        PECINT_REG_FALL: next_prdata[PECINT_PINS-1:0] = falling_edge_enable;
        PECINT_REG_FLAG: next_prdata[PECINT_PINS-1:0] = pin_change_flags;
        PECINT_REG_CTRL: begin
          next_prdata[PECINT_CTRL_MASTER_BIT] = change_irq_master_enable;
          next_prdata[PECINT_CTRL_SUMMARY_BIT] = change_irq_summary_flag;
        end
        PECINT_REG_NONE: next_prdata = PECINT_DATA_ZERO;
      endcase
    end
  end

  // Request and wake follow the flags register in the same edge, so a woken core
  // always finds the flag already recorded.
  always_comb begin
    next_change_irq = (|next_pin_change_flags) && next_change_irq_master_enable;
    next_wake_request = next_change_irq && sleep_state;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= PECINT_DATA_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
      change_irq <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      change_irq <= next_change_irq;
      wake_request <= next_wake_request;
    end
  end
endmodule
`default_nettype wire

/* File: verification/pecint_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module pecint_top_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire pecint_pkg::pecint_data_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core
  input wire logic sleep_state,
  input wire logic change_irq,
  input wire logic wake_request
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("pready held");
  a_ready_sel: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_zero: assert property (pslverr |-> prdata == 32'h0000_0000)
    else $error("data on refused read");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_wake_irq: assert property (wake_request |-> change_irq)
    else $error("wake without irq");
  a_wake_sleep: assert property (wake_request |-> $past(sleep_state))
    else $error("wake while awake");
  a_irq_fall: assert property ($fell(change_irq) |-> $past(pready && pwrite))
    else $error("irq fell without write");
endmodule
bind pecint_top pecint_top_props pecint_top_props_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sleep_state(sleep_state), .change_irq(change_irq),
  .wake_request(wake_request));
`default_nettype wire

/* File: verification/pecint_pin_src.sv */
`timescale 1ns/1ps
`default_nettype none
module pecint_pin_src (
  input wire logic pclk,
  output pecint_pkg::pecint_pins_t port_pin_n,
  output logic sleep_state
);
  initial begin
    port_pin_n = 8'h00;
    sleep_state = 1'h0;
  end
  // Pins move only after an edge, held at least a cycle
  task automatic drive(input pecint_pkg::pecint_pins_t p, input logic s);
    @(posedge pclk);
    port_pin_n <= p;
    sleep_state <= s;
  endtask
endmodule
`default_nettype wire

/* File: verification/pecint_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin total_checks++; if ((e) !== (g)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module pecint_top_tb;
  import pecint_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  pecint_addr_t paddr = 12'h000;
  pecint_strb_t pstrb = 4'hf, lanes = 4'hf;
  pecint_data_t pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, change_irq, wake_request, sleep_state;
  pecint_pins_t port_pin_n;
  int fails = 0, total_checks = 0;
  always #12.5 pclk = ~pclk;
  pecint_top pecint_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_pin_n(port_pin_n), .sleep_state(sleep_state),
    .change_irq(change_irq), .wake_request(wake_request));
  pecint_pin_src pecint_pin_src_i (.pclk(pclk), .port_pin_n(port_pin_n),
    .sleep_state(sleep_state));
  task automatic apb(input logic w, input pecint_addr_t a, input pecint_pins_t d,
      output pecint_data_t q, output logic e);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    pstrb <= lanes;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input pecint_addr_t a, input pecint_pins_t d);
    pecint_data_t q;
    logic e;
    apb(1'h1, a, d, q, e);
  endtask
  task automatic rd(input string n, input pecint_addr_t a, input pecint_data_t x,
      input logic xe = 1'h0);
    pecint_data_t q;
    logic e;
    apb(1'h0, a, 8'h00, q, e);
    `CHK(n, x, q)
    `CHK(n, xe, e)
  endtask
  // Edge seen three edges after the pin moves; five gives margin
  task automatic pins(input pecint_pins_t p, input logic s);
    pecint_pin_src_i.drive(p, s);
    repeat (5) @(posedge pclk);
  endtask
  // Safe clear: invert the flags read, AND into a fresh read, write back
  task automatic clr;
    pecint_data_t q;
    pecint_data_t r;
    logic e;
    apb(1'h0, PECINT_FLAG_OFF, 8'h00, q, e);
    apb(1'h0, PECINT_FLAG_OFF, 8'h00, r, e);
    wr(PECINT_FLAG_OFF, r[7:0] & (q[7:0] ^ 8'hff));
    rd("cleared", PECINT_FLAG_OFF, 32'h0);
    `CHK("irq off", 1'h0, change_irq)
  endtask
  task automatic t_reset;
    rd("rise rst", PECINT_RISE_OFF, 32'h0);
    rd("fall rst", PECINT_FALL_OFF, 32'h0);
    rd("flag rst", PECINT_FLAG_OFF, 32'h0);
    rd("unmapped", 12'h010, 32'h0, 1'h1);
    wr(PECINT_FALL_OFF, 8'ha5);
    rd("fall rw", PECINT_FALL_OFF, 32'ha5);
    lanes = 4'h0;
    wr(PECINT_RISE_OFF, 8'h3c);
    lanes = 4'hf;
    rd("no lane", PECINT_RISE_OFF, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_rise;
    wr(PECINT_FALL_OFF, 8'h00);
    wr(PECINT_RISE_OFF, 8'h0f);
    wr(PECINT_CTRL_OFF, 8'h01);
    pins(8'hff, 1'h0);
    rd("rise flags", PECINT_FLAG_OFF, 32'h0f);
    `CHK("irq on", 1'h1, change_irq)
    rd("summary", PECINT_CTRL_OFF, 32'h3);
    pins(8'h00, 1'h0);
    rd("no fall", PECINT_FLAG_OFF, 32'h0f);
    clr();
    $display("t_rise done");
  endtask
  task automatic t_both;
    wr(PECINT_CTRL_OFF, 8'h00);
    wr(PECINT_RISE_OFF, 8'hf0);
    wr(PECINT_FALL_OFF, 8'hff);
    pins(8'hff, 1'h0);
    rd("both up", PECINT_FLAG_OFF, 32'hf0);
    pins(8'h00, 1'h0);
    rd("both dn", PECINT_FLAG_OFF, 32'hff);
    `CHK("irq masked", 1'h0, change_irq)
    rd("sum masked", PECINT_CTRL_OFF, 32'h2);
    clr();
    wr(PECINT_CTRL_OFF, 8'h02);
    rd("sum ro", PECINT_CTRL_OFF, 32'h0);
    $display("t_both done");
  endtask
  task automatic t_wake;
    wr(PECINT_CTRL_OFF, 8'h01);
    pins(8'h00, 1'h1);
    `CHK("no wake", 1'h0, wake_request)
    pins(8'h80, 1'h1);
    `CHK("wake", 1'h1, wake_request)
    rd("sleep flag", PECINT_FLAG_OFF, 32'h80);
    pins(8'h80, 1'h0);
    `CHK("awake", 1'h0, wake_request)
    clr();
    pecint_pin_src_i.drive(8'h00, 1'h0);
    wr(PECINT_FLAG_OFF, 8'h00);
    rd("set wins", PECINT_FLAG_OFF, 32'h80);
    clr();
    $display("t_wake done");
  endtask
  // Pin moves after edge 0; two sync stages put the request at edge 3
  task automatic t_lag;
    wr(PECINT_RISE_OFF, 8'h01);
    wr(PECINT_FALL_OFF, 8'h00);
    pecint_pin_src_i.drive(8'h01, 1'h0);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    `CHK("sync lag", 1'h0, change_irq)
    @(negedge pclk);
    `CHK("sync edge", 1'h1, change_irq)
    rd("lag flag", PECINT_FLAG_OFF, 32'h01);
    clr();
    $display("t_lag done");
  endtask
  // Reset in mid-run clears enables, flags, request and wake
  task automatic t_rerst;
    wr(PECINT_FALL_OFF, 8'hff);
    pins(8'h00, 1'h1);
    `CHK("pre rst", 1'h1, wake_request)
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    `CHK("irq rst", 1'h0, change_irq)
    `CHK("wake rst", 1'h0, wake_request)
    rd("rise rerst", PECINT_RISE_OFF, 32'h0);
    rd("fall rerst", PECINT_FALL_OFF, 32'h0);
    rd("flag rerst", PECINT_FLAG_OFF, 32'h0);
    rd("ctrl rerst", PECINT_CTRL_OFF, 32'h0);
    pecint_pin_src_i.drive(8'h00, 1'h0);
    $display("t_rerst done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_rise();
    t_both();
    t_wake();
    t_lag();
    t_rerst();
    test_done();
  end
  initial begin
    #50000;
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
